// ### sram_safety_pkg.sv
// Purpose: Shared constants for the SRAM safety handler and its init sequencer
// Assumes: APB register map with 32-bit aligned words
// Notes: Event vector bit order is CE, UE, AE from bit 0 upward
package sram_safety_pkg;

    localparam int unsigned APB_AW = 12;
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_ECCD = 12'h004;
    localparam logic [11:0] OFS_FAULT = 12'h008;
    localparam logic [11:0] OFS_INFO = 12'h00c;

    localparam int unsigned CTRL_W = 2;
    localparam int unsigned CTRL_SELFTEST_BIT = 0;
    localparam int unsigned CTRL_MAP_BIT = 1;

    localparam int unsigned EV_W = 3;
    localparam int unsigned EV_CE = 0;
    localparam int unsigned EV_UE = 1;
    localparam int unsigned EV_AE = 2;

    localparam int unsigned FLT_W = 2;
    localparam int unsigned FLT_OPERR_BIT = 0;
    localparam int unsigned FLT_ADDR_BIT = 1;
    localparam int unsigned FLT_BUSY_BIT = 8;

    localparam int unsigned MEM_AW = 16;
    localparam int unsigned INFO_W = EV_W + MEM_AW;

    localparam int unsigned INIT_AW = 8;
    localparam logic [7:0] INIT_FIRST = 8'h00;
    localparam logic [7:0] INIT_LAST = 8'hff;

    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [2:0] ECCD_RST = 3'h0;
    localparam logic [1:0] FLT_RST = 2'h0;
    localparam logic [18:0] INFO_RST = 19'h00000;
    localparam logic [31:0] RDATA_RST = 32'h00000000;

endpackage

// ### sram_init_sequencer.sv
// Purpose: Walks the protected memory writing zeros after a mode change
// Assumes: One write per enabled cycle; memory accepts every write
// Notes: A new start during a walk restarts it from the first word
`timescale 1ns/1ps
`default_nettype none

module sram_init_sequencer
    import sram_safety_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic clkEn,
    input wire logic start,
    output logic initWrEn,
    output logic [INIT_AW-1:0] initAddr
);

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b01,
        SEQ_RUN = 2'b10
    } seq_state_t;

    typedef struct packed {
        seq_state_t st;
        logic [INIT_AW-1:0] addr;
        logic wr;
    } seq_t;

    seq_t s_reg;
    seq_t s_next;

    always_comb
    begin
        s_next = s_reg;
        case (s_reg.st)
            SEQ_IDLE:
            begin
                s_next.wr = 1'b0;
                if (start)
                begin
                    s_next.st = SEQ_RUN;
                    s_next.addr = INIT_FIRST;
                    s_next.wr = 1'b1;
                end
            end
            SEQ_RUN:
            begin
                if (start)
                begin
                    // Restart so no stale word survives a second switch
                    s_next.addr = INIT_FIRST;
                end
                else if (s_reg.addr == INIT_LAST)
                begin
                    s_next.st = SEQ_IDLE;
                    s_next.wr = 1'b0;
                end
                else
                begin
                    s_next.addr = s_reg.addr + 8'h01;
                end
            end
            default:
            begin
                s_next.st = SEQ_IDLE;
                s_next.wr = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            s_reg <= '{st: SEQ_IDLE, addr: INIT_FIRST, wr: 1'b0};
        end
        else if (clkEn)
        begin
            s_reg <= s_next;
        end
    end

    assign initWrEn = s_reg.wr;
    assign initAddr = s_reg.addr;

endmodule // sram_init_sequencer

`default_nettype wire

// ### sram_safety_handler.sv
// Purpose: Per-SRAM safety handler: alarms, error logging, owner notification, memory init
// Assumes: SRAM error strobes come from logic on clk, valid with memAccess
// Notes: Registers on APB, one wait-free access phase per transfer
// Notes on behaviour
// - Correctable ECC on a read raises the correctable alarm.
// - Uncorrectable ECC on a read raises the uncorrectable alarm.
// - Address error on read or write raises the address alarm.
// - Alarm follows the faulty access itself, never a later access.
// - Status registers capture errors whether or not the alarm is seen.
// - Errors are also signalled straight to the owning module.
// - After reset no alarm or status bit is set.
// - Real errors log nonzero info; zero info with a flag means spurious.
// - Switching self test or memory mapping triggers memory initialization.
`timescale 1ns/1ps
`default_nettype none

module sram_safety_handler
    import sram_safety_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic memAccess,
    input wire logic memWrite,
    input wire logic eccCorr,
    input wire logic eccUncorr,
    input wire logic addrErr,
    input wire logic [MEM_AW-1:0] memAddr,
    output logic alarmCe,
    output logic alarmUe,
    output logic alarmAe,
    output logic ownerCe,
    output logic ownerUe,
    output logic ownerAe,
    output logic initWrEn,
    output logic [INIT_AW-1:0] initAddr
);

    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [EV_W-1:0] eccd;
        logic [FLT_W-1:0] fault;
        logic [INFO_W-1:0] info;
        logic [EV_W-1:0] alarm;
        logic [EV_W-1:0] owner;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
    } hdl_t;

    hdl_t s_reg;
    hdl_t s_next;

    logic evRead;
    logic [EV_W-1:0] ev;
    logic setupPh;
    logic wrDone;
    logic startInit;

    assign evRead = memAccess && !memWrite;
    // Same-cycle capture: the alarm never waits for another access
    assign ev[EV_CE] = evRead && eccCorr;
    assign ev[EV_UE] = evRead && eccUncorr;
    assign ev[EV_AE] = memAccess && addrErr;

    assign setupPh = psel && !penable;
    assign wrDone = psel && penable && s_reg.ready && pwrite;
    // Only a real change of mode starts a walk, a rewrite of the same value does not
    assign startInit = wrDone && (paddr == OFS_CTRL) && (pwdata[CTRL_W-1:0] != s_reg.ctrl);

    always_comb
    begin
        s_next = s_reg;
        s_next.alarm = ev;
        s_next.owner = ev;
        s_next.ready = 1'b0;
        s_next.slverr = 1'b0;
        if (setupPh)
        begin
            s_next.ready = 1'b1;
            s_next.rdata = RDATA_RST;
            case (paddr)
                OFS_CTRL: s_next.rdata[CTRL_W-1:0] = s_reg.ctrl;
                OFS_ECCD: s_next.rdata[EV_W-1:0] = s_reg.eccd;
                OFS_FAULT:
                begin
                    s_next.rdata[FLT_W-1:0] = s_reg.fault;
                    s_next.rdata[FLT_BUSY_BIT] = initWrEn;
                end
                OFS_INFO: s_next.rdata[INFO_W-1:0] = s_reg.info;
                default: s_next.slverr = 1'b1;
            endcase
        end
        else if (psel && penable && s_reg.ready)
        begin
            s_next.rdata = s_reg.rdata;
        end
        if (wrDone)
        begin
            case (paddr)
                OFS_CTRL: s_next.ctrl = pwdata[CTRL_W-1:0];
                OFS_ECCD: s_next.eccd = s_reg.eccd & ~pwdata[EV_W-1:0];
                OFS_FAULT: s_next.fault = s_reg.fault & ~pwdata[FLT_W-1:0];
                OFS_INFO: s_next.info = INFO_RST;
                default: s_next.ctrl = s_reg.ctrl;
            endcase
        end
        // Set after clear so an event in the clearing cycle is kept
        s_next.eccd = s_next.eccd | ev;
        s_next.fault[FLT_OPERR_BIT] = s_next.fault[FLT_OPERR_BIT] | ev[EV_UE];
        s_next.fault[FLT_ADDR_BIT] = s_next.fault[FLT_ADDR_BIT] | ev[EV_AE];
        if (|ev)
        begin
            // Class bits are nonzero, so real errors never log zero
            s_next.info = {ev, memAddr};
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            // Reset leaves every flag and alarm clear
            s_reg <= '{ctrl: CTRL_RST, eccd: ECCD_RST, fault: FLT_RST, info: INFO_RST,
                       alarm: ECCD_RST, owner: ECCD_RST, rdata: RDATA_RST,
                       ready: 1'b0, slverr: 1'b0};
        end
        else if (clkEn)
        begin
            s_reg <= s_next;
        end
    end

    sram_init_sequencer initSeq (
        .clk(clk),
        .srst(srst),
        .clkEn(clkEn),
        .start(startInit),
        .initWrEn(initWrEn),
        .initAddr(initAddr)
    );

    assign prdata = s_reg.rdata;
    assign pready = s_reg.ready;
    assign pslverr = s_reg.slverr;
    assign alarmCe = s_reg.alarm[EV_CE];
    assign alarmUe = s_reg.alarm[EV_UE];
    assign alarmAe = s_reg.alarm[EV_AE];
    assign ownerCe = s_reg.owner[EV_CE];
    assign ownerUe = s_reg.owner[EV_UE];
    assign ownerAe = s_reg.owner[EV_AE];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    sequence rdCorrSeq;
        clkEn && memAccess && !memWrite && eccCorr;
    endsequence

    sequence rdUncorrSeq;
        clkEn && memAccess && !memWrite && eccUncorr;
    endsequence

    sequence addrFaultSeq;
        clkEn && memAccess && addrErr;
    endsequence

    AST_CE_ALARM: assert property (rdCorrSeq |=> alarmCe) else $error("ce alarm missing");
    AST_UE_ALARM: assert property (rdUncorrSeq |=> alarmUe) else $error("ue alarm missing");
    AST_AE_ALARM: assert property (addrFaultSeq |=> alarmAe) else $error("ae alarm missing");
    AST_WRITE_NO_ECC: assert property (clkEn && memAccess && memWrite |=> !alarmCe && !alarmUe)
        else $error("ecc alarm on write");

    // Each alarm must trace back to the access one cycle earlier, never a later one
    AST_ALARM_CAUSE: assert property (alarmUe && $past(clkEn) |-> $past(memAccess && !memWrite && eccUncorr))
        else $error("ue alarm without same access");
    AST_CE_CAUSE: assert property (alarmCe && $past(clkEn) |-> $past(memAccess && !memWrite && eccCorr))
        else $error("ce alarm without same access");
    AST_AE_CAUSE: assert property (alarmAe && $past(clkEn) |-> $past(memAccess && addrErr))
        else $error("ae alarm without same access");

    // Status capture must not lean on the alarm path being seen downstream
    AST_STATUS_CAPTURE: assert property (rdUncorrSeq |=> s_reg.eccd[EV_UE] && s_reg.fault[FLT_OPERR_BIT])
        else $error("ue status not captured");
    AST_AE_STATUS: assert property (addrFaultSeq |=> s_reg.eccd[EV_AE] && s_reg.fault[FLT_ADDR_BIT])
        else $error("ae status not captured");
    AST_OWNER_NOTIFY: assert property (addrFaultSeq |=> ownerAe ##0 alarmAe)
        else $error("owner not notified");
    AST_CE_OWNER: assert property (rdCorrSeq |=> ownerCe) else $error("ce owner notice missing");
    AST_UE_OWNER: assert property (rdUncorrSeq |=> ownerUe) else $error("ue owner notice missing");

    AST_RESET_QUIET: assert property (@(posedge clk) disable iff (1'b0)
        srst |=> !alarmCe && !alarmUe && !alarmAe && !ownerCe && !ownerUe && !ownerAe
        && s_reg.eccd == ECCD_RST && s_reg.fault == FLT_RST && s_reg.info == INFO_RST && !initWrEn)
        else $error("flag set after reset");
    AST_INFO_NONZERO: assert property ((rdCorrSeq or rdUncorrSeq or addrFaultSeq) |=> s_reg.info != 19'h00000)
        else $error("error info zero after real error");
    AST_INIT_START: assert property (clkEn && startInit |=> initWrEn && initAddr == INIT_FIRST)
        else $error("init walk not started");
    AST_INIT_END: assert property (clkEn && initWrEn && initAddr == INIT_LAST && !startInit |=> !initWrEn)
        else $error("init walk overran last word");
    AST_PULSE_ONLY: assert property (clkEn && !memAccess |=> !alarmCe && !alarmUe && !alarmAe)
        else $error("alarm not a single pulse");

    // Frozen cycles must change nothing, or a dropped event could surface a cycle late
    AST_FREEZE: assert property (!clkEn |=> $stable(s_reg))
        else $error("state moved while frozen");

endmodule // sram_safety_handler

`default_nettype wire

// ### sram_far_side_model.sv
// Purpose: SRAM macro side and alarm collector facing the safety handler
// Assumes: one access request per cycle from the bench, held a single cycle
// Notes: strobes are only valid with memAccess; idle cycles invert them
`timescale 1ns/1ps
`default_nettype none

module sram_far_side_model
(
    input wire logic clk,
    input wire logic srst,
    input wire logic req,
    input wire logic [3:0] kind,
    input wire logic [15:0] addr,
    input wire logic [2:0] alarms,
    output logic memAccess,
    output logic memWrite,
    output logic eccCorr,
    output logic eccUncorr,
    output logic addrErr,
    output logic [15:0] memAddr,
    output int alarmCount
);
    // One process owns every output; reset also starts a fresh collector tally
    always @(posedge clk)
    begin
        if (srst)
        begin
            {memAccess, memWrite, addrErr, eccUncorr, eccCorr} <= 5'h0;
            memAddr <= 16'h0;
            alarmCount <= 0;
        end
        else
        begin
            memAccess <= req;
            if (req)
            begin
                {memWrite, addrErr, eccUncorr, eccCorr} <= kind;
                memAddr <= addr;
            end
            else
            begin
                // A handler that ignores memAccess would see stray errors here
                {memWrite, addrErr, eccUncorr, eccCorr} <= ~{memWrite, addrErr, eccUncorr, eccCorr};
                memAddr <= ~memAddr;
            end
            alarmCount <= alarmCount + alarms[0] + alarms[1] + alarms[2];
        end
    end
endmodule // sram_far_side_model
`default_nettype wire

// ### tb_top.sv
// Purpose: Self-checking bench for the SRAM safety handler
// Assumes: clkEn high except in the freeze case, so the slave answers without waits
// Notes: error classes run from a table; reset and init walks by hand
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import sram_safety_pkg::*;
;
    typedef struct packed {logic [3:0] kind; logic [2:0] pulse;} row_t;
    // kind is {write, AE, UE, CE}; pulse is {AE, UE, CE}
    row_t rows [7] = '{'{4'h1, 3'h1}, '{4'h2, 3'h2}, '{4'h4, 3'h4}, '{4'hc, 3'h4},
        '{4'hb, 3'h0}, '{4'h5, 3'h5}, '{4'h0, 3'h0}};
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic clkEn = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic req = 1'b0;
    logic [APB_AW-1:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] kind = 4'h0;
    logic [15:0] addr = 16'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, initWrEn;
    logic memAccess, memWrite, eccCorr, eccUncorr, addrErr;
    logic alarmCe, alarmUe, alarmAe, ownerCe, ownerUe, ownerAe;
    logic [15:0] memAddr;
    logic [INIT_AW-1:0] initAddr;
    logic [2:0] ctrlSeq [3] = '{3'h1, 3'h1, 3'h3};
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;
    int alarmCount;

    sram_safety_handler DUT (.clk(clk), .srst(srst), .clkEn(clkEn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .memAccess(memAccess), .memWrite(memWrite), .eccCorr(eccCorr),
        .eccUncorr(eccUncorr), .addrErr(addrErr), .memAddr(memAddr), .alarmCe(alarmCe),
        .alarmUe(alarmUe), .alarmAe(alarmAe), .ownerCe(ownerCe), .ownerUe(ownerUe),
        .ownerAe(ownerAe), .initWrEn(initWrEn), .initAddr(initAddr));

    sram_far_side_model farSide (.clk(clk), .srst(srst), .req(req), .kind(kind), .addr(addr),
        .alarms({alarmAe, alarmUe, alarmCe}), .memAccess(memAccess), .memWrite(memWrite),
        .eccCorr(eccCorr), .eccUncorr(eccUncorr), .addrErr(addrErr), .memAddr(memAddr),
        .alarmCount(alarmCount));

    initial
    begin
        forever #4 clk = ~clk;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Idle edge at the end keeps psel from being driven twice in one step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic access(input logic [3:0] k, input logic [15:0] a, input logic [2:0] exp);
        req <= 1'b1;
        kind <= k;
        addr <= a;
        @(posedge clk);
        req <= 1'b0;
        repeat (2) @(posedge clk);
        chk("alarm", {29'h0, exp}, {29'h0, alarmAe, alarmUe, alarmCe});
        chk("owner", {29'h0, exp}, {29'h0, ownerAe, ownerUe, ownerCe});
        @(posedge clk);
        chk("pulse end", 32'h0, {26'h0, alarmAe, alarmUe, alarmCe, ownerAe, ownerUe, ownerCe});
    endtask

    task automatic zeros();
        for (int a = 0; a < 16; a += 4)
        begin
            apb(1'b0, 12'(a), 32'h0);
            chk("reg after reset", 32'h0, rd);
        end
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            num_errors++;
            wrap_up();
        end
    end

    initial
    begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        zeros();
        foreach (rows[i])
        begin
            access(rows[i].kind, 16'h1230 + 16'(i), rows[i].pulse);
            if (rows[i].pulse != 3'h0)
            begin
                apb(1'b0, OFS_INFO, 32'h0);
                chk("info", {13'h0, rows[i].pulse, 16'h1230 + 16'(i)}, rd);
            end
        end
        chk("collected", 32'd6, 32'(alarmCount));
        apb(1'b0, OFS_ECCD, 32'h0);
        chk("eccd", 32'h7, rd);
        apb(1'b0, OFS_FAULT, 32'h0);
        chk("fault", 32'h3, rd);
        apb(1'b1, OFS_ECCD, 32'h7);
        apb(1'b1, OFS_FAULT, 32'h3);
        apb(1'b1, OFS_INFO, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        zeros();
        // Frozen clock enable drops the access: no pulse now, none later, no status
        clkEn <= 1'b0;
        access(4'h2, 16'h0077, 3'h0);
        clkEn <= 1'b1;
        apb(1'b0, OFS_ECCD, 32'h0);
        chk("frozen eccd", 32'h0, rd);
        // Same value twice must not restart the walk
        foreach (ctrlSeq[j])
        begin
            apb(1'b1, OFS_CTRL, {29'h0, ctrlSeq[j]});
            for (int k = 0; k < 257; k++)
            begin
                chk("init", {23'h0, j != 1 && k < 256, (j != 1 && k < 256) ? 8'(k) : 8'h0},
                    {23'h0, initWrEn, initWrEn ? initAddr : 8'h0});
                @(posedge clk);
            end
        end
        // Busy shows in the fault register while a walk runs
        apb(1'b1, OFS_CTRL, 32'h0);
        apb(1'b0, OFS_FAULT, 32'h0);
        chk("busy", 32'h100, rd);
        // A second change mid-walk must begin again at the first word
        apb(1'b1, OFS_CTRL, 32'h2);
        chk("restart", 32'h100, {23'h0, initWrEn, initAddr});
        access(4'h2, 16'h0042, 3'h2);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        zeros();
        // Clean read after reset must raise no alarm and no owner notice
        access(4'h0, 16'h0000, 3'h0);
        wrap_up();
    end
endmodule // tb_top
`default_nettype wire
